// ===== hdl/cca_sync.sv
// Three-flop input synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module cca_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] lvl_q,
	output logic      [W-1:0] rise_q,
	output logic      [W-1:0] fall_q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] chg;

	if (W < 1) begin : g_bad
		$error("cca_sync: W must be at least 1");
	end

	// A change counts once the second and third stages agree
	assign chg = ~(s2_q ^ s3_q) & (s3_q ^ lvl_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q   <= '0;
			s2_q   <= '0;
			s3_q   <= '0;
			lvl_q  <= '0;
			rise_q <= '0;
			fall_q <= '0;
		end else begin
			s1_q   <= din;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			lvl_q  <= lvl_q ^ chg;
			rise_q <= chg & s3_q;
			fall_q <= chg & ~s3_q;
		end
	end
endmodule : cca_sync
`default_nettype wire

// ===== hdl/cca_timer.sv
// Reloadable time base with count clock selection
`timescale 1ns/1ps
`default_nettype none
`include "cca_params.svh"
module cca_timer #(
	parameter int TW = 16
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire cca_pkg::cca_tcfg_s cfg,
	input  wire logic [3:0]         presc,
	input  wire logic               sixth_general_timer_ovf,
	input  wire logic               ext_rise,
	input  wire logic               ext_fall,
	input  wire logic               stag_ok,
	input  wire logic               wr_val,
	input  wire logic               wr_rel,
	input  wire logic [TW-1:0]      wdata,
	output logic      [TW-1:0]      val_q,
	output logic      [TW-1:0]      rel_q,
	output logic                    upd_q,
	output logic                    ovf_q
);
	import cca_pkg::*;

	logic sel_en;
	logic tick;
	logic wrap;

	if (TW < 2 || TW > 16) begin : g_bad
		$error("cca_timer: TW must lie in 2..16");
	end

	always_comb begin
		unique case (cfg.clksel)
			3'h0, 3'h1, 3'h2, 3'h3: sel_en = presc[cfg.clksel[1:0]];
			`CCA_CLK_SIXTH:         sel_en = sixth_general_timer_ovf;
			`CCA_CLK_EXR:           sel_en = ext_rise;
			`CCA_CLK_EXF:           sel_en = ext_fall;
			`CCA_CLK_OFF:           sel_en = 1'b0;
		endcase
	end

	assign tick = cfg.run & stag_ok & sel_en & ~wr_val;
	assign wrap = &val_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			val_q <= TW'(`CCA_TMR_RST);
			rel_q <= TW'(`CCA_REL_RST);
			upd_q <= 1'b0;
			ovf_q <= 1'b0;
		end else begin
			if (wr_rel)
				rel_q <= wdata;
			if (wr_val)
				val_q <= wdata;
			else if (tick)
				val_q <= wrap ? rel_q : val_q + 1'b1;
			upd_q <= tick;
			ovf_q <= tick & wrap;
		end
	end
endmodule : cca_timer
`default_nettype wire

// ===== hdl/cca_top.sv
// Capture/compare array: APB registers, two time bases, channel array
// Function
// - Up to sixteen channels, one system clock resolution normally.
// - Staggered operation coarsens timing resolution to eight clocks.
// - Two independent 16-bit timers, each with a reload register.
// - Timer count clock: prescaled system clock or sixth timer overflow.
// - Timers may also count external input edges.
// - Each channel picks its timer and capture or compare use.
// - Each channel owns one pin: capture input or compare output.
// - Capture latches the assigned timer value on a pin event.
// - Every capture raises that channel's interrupt request.
// - Capture edge per channel: rising, falling or both.
// - Compare channels match their timer continuously; act on equality.
// - Mode 0: interrupt only, several matches per period.
// - Mode 1: pin toggles on every match.
// - Mode 2: interrupt only, one per timer period.
// - Mode 3: pin set on match, cleared on timer overflow.
// - Double register: two channels toggle one shared pin.
// - Single event option limits a channel to one edge or pulse.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cca_params.svh"
module cca_top #(
	parameter int NCH = 16
) (
	input  wire logic           pclk,
	input  wire logic           presetn,
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [7:0]     paddr,
	input  wire logic [31:0]    pwdata,
	output logic      [31:0]    prdata,
	output logic                pready,
	output logic                pslverr,
	input  wire logic [NCH-1:0] pin_i,
	output logic      [NCH-1:0] pin_o,
	output logic      [NCH-1:0] pin_oe_n,
	input  wire logic           sixth_general_timer_ovf,
	input  wire logic [1:0]     ext_cnt_i,
	output logic                irq
);
	import cca_pkg::*;

	localparam int SW = NCH + 2;
	localparam int HALF = NCH / 2;

	if (NCH < 2 || NCH > 16 || (NCH % 2) != 0) begin : g_bad
		$error("cca_top: NCH must be even and lie in 2..16");
	end

	// Bus side
	logic            setup;
	logic            wr_en;
	logic [31:0]     rd_mux;
	logic            hit;
	logic [31:0]     prdata_q;
	logic            err_q;
	logic            a_ctrl;
	logic            a_stat;
	logic            a_mask;
	logic [1:0]      a_tcfg;
	logic [1:0]      a_tval;
	logic [1:0]      a_trel;
	logic            a_chcfg;
	logic            a_chval;
	logic [3:0]      ch_idx;
	logic            ch_ok;

	// Control and interrupt state
	logic            ctrl_q;
	logic [SW-1:0]   stat_q;
	logic [SW-1:0]   stat_d;
	logic [SW-1:0]   mask_q;
	logic [SW-1:0]   stat_set;
	logic [SW-1:0]   stat_clr;

	// Time bases
	cca_tcfg_s       tcfg_q [2];
	logic [1:0][15:0] tval;
	logic [1:0][15:0] trel;
	logic [1:0]      tupd;
	logic [1:0]      tovf;
	logic [`CCA_PRE_W-1:0]  pre_q;
	logic [`CCA_STAG_W-1:0] slot_q;
	logic [3:0]      presc;
	logic            stag_ok;

	// Synchronised pins and count inputs
	logic [SW-1:0]   in_lvl;
	logic [SW-1:0]   in_rise;
	logic [SW-1:0]   in_fall;

	// Channel results
	logic [NCH-1:0]  match_v;
	logic [NCH-1:0]  ev_v;
	logic [NCH-1:0][7:0]  cfg_rd;
	logic [NCH-1:0][15:0] cc_rd;

	// Zero wait state slave: read data is latched in the setup cycle
	assign setup   = psel & ~penable;
	assign wr_en   = psel & penable & pwrite & hit;
	assign pready  = penable;
	assign prdata  = prdata_q;
	assign pslverr = penable & err_q;

	assign a_ctrl  = paddr == `CCA_CTRL;
	assign a_stat  = paddr == `CCA_STAT;
	assign a_mask  = paddr == `CCA_MASK;
	assign a_tcfg[0] = paddr == `CCA_TBASE0 + `CCA_TOFF_CFG;
	assign a_tval[0] = paddr == `CCA_TBASE0 + `CCA_TOFF_VAL;
	assign a_trel[0] = paddr == `CCA_TBASE0 + `CCA_TOFF_REL;
	assign a_tcfg[1] = paddr == `CCA_TBASE1 + `CCA_TOFF_CFG;
	assign a_tval[1] = paddr == `CCA_TBASE1 + `CCA_TOFF_VAL;
	assign a_trel[1] = paddr == `CCA_TBASE1 + `CCA_TOFF_REL;
	assign ch_idx  = paddr[5:2];
	assign ch_ok   = ({1'b0, ch_idx} < 5'(NCH)) & (paddr[1:0] == 2'h0);
	assign a_chcfg = (paddr[7:6] == `CCA_CHCFG_RGN) & ch_ok;
	assign a_chval = (paddr[7:6] == `CCA_CHVAL_RGN) & ch_ok;
	assign hit = a_ctrl | a_stat | a_mask | (|a_tcfg) | (|a_tval)
		| (|a_trel) | a_chcfg | a_chval;

	assign rd_mux =
		a_ctrl    ? 32'(ctrl_q) :
		a_stat    ? 32'(stat_q) :
		a_mask    ? 32'(mask_q) :
		a_tcfg[0] ? 32'(tcfg_q[0]) :
		a_tval[0] ? 32'(tval[0]) :
		a_trel[0] ? 32'(trel[0]) :
		a_tcfg[1] ? 32'(tcfg_q[1]) :
		a_tval[1] ? 32'(tval[1]) :
		a_trel[1] ? 32'(trel[1]) :
		a_chcfg   ? 32'(cfg_rd[ch_idx]) :
		a_chval   ? 32'(cc_rd[ch_idx]) :
		32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			err_q    <= 1'b0;
		end else if (setup) begin
			prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
			err_q    <= ~hit;
		end
	end

	// Control, mask and timer configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q    <= `CCA_CTRL_RST;
			mask_q    <= '0;
			tcfg_q[0] <= '0;
			tcfg_q[1] <= '0;
		end else if (wr_en) begin
			if (a_ctrl)
				ctrl_q <= pwdata[`CCA_CTRL_STAG];
			if (a_mask)
				mask_q <= pwdata[SW-1:0];
			if (a_tcfg[0])
				tcfg_q[0] <= cca_tcfg_s'(pwdata[3:0]);
			if (a_tcfg[1])
				tcfg_q[1] <= cca_tcfg_s'(pwdata[3:0]);
		end
	end

	// Sticky status: a new event beats a write-one clear in the same cycle
	assign stat_set = {tovf, ev_v};
	assign stat_clr = (wr_en & a_stat) ? pwdata[SW-1:0] : '0;
	assign stat_d   = (stat_q & ~stat_clr) | stat_set;
	assign irq      = |(stat_q & mask_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stat_q <= '0;
		else
			stat_q <= stat_d;
	end

	assign presc[0] = 1'b1;
	assign presc[1] = &pre_q[1:0];
	assign presc[2] = &pre_q[3:0];
	assign presc[3] = &pre_q;
	assign stag_ok  = ~ctrl_q | (slot_q == '0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q  <= '0;
			slot_q <= '0;
		end else begin
			pre_q  <= pre_q + 1'b1;
			slot_q <= slot_q + 1'b1;
		end
	end

	cca_sync #(
		.W (SW)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({ext_cnt_i, pin_i}),
		.lvl_q   (in_lvl),
		.rise_q  (in_rise),
		.fall_q  (in_fall)
	);

	for (genvar t = 0; t < 2; t++) begin : g_tmr
		cca_timer #(
			.TW (16)
		) u_tmr (
			.pclk     (pclk),
			.presetn  (presetn),
			.cfg      (tcfg_q[t]),
			.presc    (presc),
			.sixth_general_timer_ovf (sixth_general_timer_ovf),
			.ext_rise (in_rise[NCH+t]),
			.ext_fall (in_fall[NCH+t]),
			.stag_ok  (stag_ok),
			.wr_val   (wr_en & a_tval[t]),
			.wr_rel   (wr_en & a_trel[t]),
			.wdata    (pwdata[15:0]),
			.val_q    (tval[t]),
			.rel_q    (trel[t]),
			.upd_q    (tupd[t]),
			.ovf_q    (tovf[t])
		);
	end

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		cca_chcfg_s  cfg_q;
		logic [15:0] cc_q;
		logic        pin_q;
		logic        armed_q;
		logic        done_q;
		logic [15:0] tv;
		logic        tu;
		logic        tov;
		logic        is_cmp;
		logic        once;
		logic        dbl_ok;
		logic        pm;
		logic        acc;
		logic        tog;
		logic        cap;
		logic        set_p;
		logic        clr_p;
		logic        wr_cfg;
		logic        wr_val;

		assign wr_cfg = wr_en & a_chcfg & (ch_idx == 4'(i));
		assign wr_val = wr_en & a_chval & (ch_idx == 4'(i));

		assign tv  = cfg_q.tsel ? tval[1] : tval[0];
		assign tu  = cfg_q.tsel ? tupd[1] : tupd[0];
		assign tov = cfg_q.tsel ? tovf[1] : tovf[0];

		assign is_cmp = cfg_q.mode inside {MODE_CMP0, MODE_CMP1, MODE_CMP2,
			MODE_CMP3};
		assign once   = cfg_q.mode inside {MODE_CMP2, MODE_CMP3};

		// match on each new timer value
		assign match_v[i] = is_cmp & tu & (tv == cc_q);

		// partner in upper half shares this pin
		assign dbl_ok = cfg_q.dbl & is_cmp & (i < HALF);
		assign pm = dbl_ok & match_v[(i + HALF) % NCH];

		// accepted match, once per period in 2 and 3
		assign acc = match_v[i] & ~done_q & (~once | armed_q);
		// toggle in mode 1 or double register
		assign tog = ~done_q & (((cfg_q.mode == MODE_CMP1) & match_v[i])
			| (dbl_ok & (match_v[i] | pm)));
		// set on match, clear on overflow
		assign set_p = acc & (cfg_q.mode == MODE_CMP3);
		assign clr_p = tov & (cfg_q.mode == MODE_CMP3);

		assign cap = (cfg_q.mode == MODE_CAP)
			& ((cfg_q.edg[0] & in_rise[i]) | (cfg_q.edg[1] & in_fall[i]));

		assign ev_v[i] = cap | acc;

		// pin driven only while it serves as an output
		assign pin_o[i]    = pin_q;
		assign pin_oe_n[i] = ~((cfg_q.mode inside {MODE_CMP1, MODE_CMP3})
			| dbl_ok);
		assign cfg_rd[i]   = cfg_q;
		assign cc_rd[i]    = cc_q;

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cfg_q   <= '0;
				cc_q    <= '0;
				pin_q   <= 1'b0;
				armed_q <= 1'b1;
				done_q  <= 1'b0;
			end else begin
				if (wr_cfg)
					cfg_q <= cca_chcfg_s'(pwdata[7:0]);
				// capture wins over a software write
				if (cap)
					cc_q <= tv;
				else if (wr_val)
					cc_q <= pwdata[15:0];
				armed_q <= wr_cfg | tov | (armed_q & ~acc);
				// single event latch, freed by reconfiguring
				done_q <= ~wr_cfg & (done_q | (cfg_q.single & (acc | tog)));
				if (set_p)
					pin_q <= 1'b1;
				else if (clr_p)
					pin_q <= 1'b0;
				else if (tog)
					pin_q <= ~pin_q;
			end
		end
	end
endmodule : cca_top
`default_nettype wire

// ===== include/cca_params.svh
// Register offsets, field positions, reset values and clock selects
`ifndef CCA_PARAMS_SVH
`define CCA_PARAMS_SVH
`define CCA_CTRL       8'h00
`define CCA_STAT       8'h04
`define CCA_MASK       8'h08
`define CCA_TBASE0     8'h10
`define CCA_TBASE1     8'h20
`define CCA_TOFF_CFG   8'h00
`define CCA_TOFF_VAL   8'h04
`define CCA_TOFF_REL   8'h08
`define CCA_CHCFG_RGN  2'h1
`define CCA_CHVAL_RGN  2'h2
`define CCA_CTRL_STAG  0
`define CCA_CTRL_RST   1'h0
`define CCA_TMR_RST    16'h0000
`define CCA_REL_RST    16'h0000
`define CCA_CLK_SIXTH  3'h4
`define CCA_CLK_EXR    3'h5
`define CCA_CLK_EXF    3'h6
`define CCA_CLK_OFF    3'h7
`define CCA_PRE_W      6
`define CCA_STAG_W     3
`endif

// ===== include/cca_pkg.sv
// Types shared by the capture/compare array
`default_nettype none
package cca_pkg;
	typedef enum logic [2:0] {
		MODE_OFF,
		MODE_CAP,
		MODE_CMP0,
		MODE_CMP1,
		MODE_CMP2,
		MODE_CMP3
	} cca_mode_e;

	typedef struct packed {
		logic       dbl;
		logic       single;
		logic [1:0] edg;
		logic       tsel;
		cca_mode_e  mode;
	} cca_chcfg_s;

	typedef struct packed {
		logic       run;
		logic [2:0] clksel;
	} cca_tcfg_s;
endpackage : cca_pkg
`default_nettype wire

// ===== verification/cca_pins.sv
// Far-side pin model: shared pin levels and sixth timer overflow pulses
`timescale 1ns/1ps
`default_nettype none
module cca_pins (
	input  wire logic        pclk,
	input  wire logic [15:0] pin_o,
	input  wire logic [15:0] pin_oe_n,
	input  wire logic [15:0] drv,
	output logic      [15:0] pin_i,
	output logic             sixth_general_timer_ovf
);
	logic [1:0] div_q = 2'h0;
	assign pin_i = (pin_o & ~pin_oe_n) | (drv & pin_oe_n);
	always @(posedge pclk) begin
		div_q <= div_q + 2'h1;
	end
	assign sixth_general_timer_ovf = (div_q == 2'h3);
endmodule : cca_pins
`default_nettype wire

// ===== verification/cca_top_props.sv
// Port assertions for the capture/compare array
`timescale 1ns/1ps
`default_nettype none
module cca_top_props #(
	parameter int NCH = 16
) (
	input wire logic           pclk,
	input wire logic           presetn,
	input wire logic           psel,
	input wire logic           penable,
	input wire logic           pwrite,
	input wire logic [7:0]     paddr,
	input wire logic [31:0]    prdata,
	input wire logic           pready,
	input wire logic           pslverr,
	input wire logic [NCH-1:0] pin_o,
	input wire logic [NCH-1:0] pin_oe_n,
	input wire logic           irq
);
	wire setup = psel & ~penable;
	wire wacc  = psel & penable & pwrite;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_READY: assert property (pready == penable)
		else $error("pready differs from penable");
	AST_ERR_ACC: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	AST_MISALIGN: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr)
		else $error("misaligned access not refused");
	AST_HOLE: assert property (setup && paddr == 8'h0c |=> pslverr)
		else $error("unmapped access not refused");
	AST_WR_RDATA: assert property (setup && pwrite |=> prdata == 32'h0)
		else $error("read data not zero on write");
	AST_RST_OUT: assert property ($rose(presetn) |-> pin_o == '0 && &pin_oe_n && !irq)
		else $error("outputs not idle after reset");
	AST_OE_CAUSE: assert property ($changed(pin_oe_n) |-> $past(wacc))
		else $error("pin enable changed without write");
	AST_PIN_CAUSE: assert property ($changed(pin_o) |-> (($past(pin_oe_n) & (pin_o ^ $past(pin_o))) == '0))
		else $error("undriven pin changed");
	AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wacc) || $past(wacc, 2))
		else $error("interrupt dropped without write");
endmodule : cca_top_props
bind cca_top cca_top_props #(.NCH(NCH)) props_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_o(pin_o),
	.pin_oe_n(pin_oe_n), .irq(irq));
`default_nettype wire

// ===== verification/cca_top_tb.sv
// Self-checking bench for the capture/compare array
`timescale 1ns/1ps
`default_nettype none
module cca_top_tb;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic        sixth_ovf;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] pin_i, pin_o, pin_oe_n, drv;
	logic [1:0]  ext;
	wire  [16:0] obs = {irq, pin_o};
	logic [7:0]  tch [7] = '{8'h0, 8'h4, 8'h8, 8'hc, 8'h10, 8'h14, 8'h34};
	logic [7:0]  tcf [7] = '{8'h3, 8'h5, 8'h2, 8'h4, 8'h43, 8'h83, 8'h3};
	logic [15:0] tcv [7] = '{16'hfff8, 16'hfff8, 16'hfff8, 16'hfff8,
		16'hfff8, 16'hfff4, 16'hfffa};
	int          n_mismatch = 0;
	int          check_count = 0;
	always #10 pclk = ~pclk;
	cca_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
		.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_cnt_i(ext),
		.sixth_general_timer_ovf(sixth_ovf), .irq(irq));
	cca_pins far_u (.pclk(pclk), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
		.drv(drv), .pin_i(pin_i), .sixth_general_timer_ovf(sixth_ovf));
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task chk_b(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask : chk_b
	task acc(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : acc
	task wr(input logic [7:0] a, input logic [31:0] d);
		acc(a, 1'b1, d);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		acc(a, 1'b0, 32'h0);
		chk(r, e);
	endtask : rd
	task poll(input int i, input logic v);
		for (int k = 0; k < 200 && obs[i] !== v; k++) @(negedge pclk);
		chk_b(obs[i], v);
	endtask : poll
	task finish_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		finish_test();
	end
	initial begin
		{presetn, psel, penable, pwrite} = 4'h0;
		{paddr, pwdata, drv, ext} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h28, 32'h0);
		chk(pin_oe_n, 16'hffff);
		wr(8'h0c, 32'hffff);
		chk_b(err, 1'b1);
		acc(8'h42, 1'b0, 32'h0);
		chk_b(err, 1'b1);
		// Timer1 counts external edges, then the sixth timer
		wr(8'h08, 32'h20000);
		wr(8'h28, 32'h1234);
		wr(8'h24, 32'hffff);
		wr(8'h20, 32'hd);
		ext <= 2'h2;
		poll(16, 1'b1);
		rd(8'h24, 32'h1234);
		wr(8'h04, 32'h3ffff);
		poll(16, 1'b0);
		wr(8'h20, 32'h7);
		wr(8'h24, 32'hfffe);
		wr(8'h20, 32'hc);
		poll(16, 1'b1);
		wr(8'h20, 32'h7);
		wr(8'h24, 32'habc);
		wr(8'h04, 32'h3ffff);
		// Capture on rising, falling, both edges
		wr(8'h60, 32'h19);
		wr(8'h64, 32'h29);
		wr(8'h68, 32'h39);
		wr(8'h08, 32'h700);
		drv <= 16'h0700;
		poll(16, 1'b1);
		repeat (10) @(posedge pclk);
		rd(8'h04, 32'h500);
		rd(8'ha0, 32'habc);
		wr(8'h04, 32'h700);
		drv <= 16'h0;
		repeat (10) @(posedge pclk);
		rd(8'h04, 32'h600);
		wr(8'h08, 32'h0);
		poll(16, 1'b0);
		wr(8'h04, 32'h3ffff);
		// Compare modes on a sixteen-cycle timer0 period
		for (int i = 0; i < 7; i++) begin
			wr(8'h40 + tch[i], {24'h0, tcf[i]});
			wr(8'h80 + tch[i], {16'h0, tcv[i]});
		end
		chk(pin_oe_n, 16'hdfcc);
		wr(8'h18, 32'hfff0);
		wr(8'h14, 32'hfff0);
		wr(8'h10, 32'h8);
		poll(0, 1'b1);
		poll(0, 1'b0);
		poll(1, 1'b1);
		poll(1, 1'b0);
		poll(5, 1'b1);
		repeat (8) @(posedge pclk);
		chk_b(pin_o[5], 1'b0);
		poll(4, 1'b1);
		repeat (40) @(posedge pclk);
		chk_b(pin_o[4], 1'b1);
		wr(8'h10, 32'h7);
		rd(8'h04, 32'h1203f);
		wr(8'h04, 32'h3);
		rd(8'h04, 32'h1203c);
		// Mode 0 repeats within a period, mode 2 waits for overflow
		wr(8'h04, 32'h3ffff);
		wr(8'h4c, 32'h4);
		wr(8'h14, 32'hfff7);
		wr(8'h10, 32'hc);
		repeat (12) @(posedge pclk);
		acc(8'h04, 1'b0, 32'h0);
		chk(r[3:2], 2'h3);
		wr(8'h04, 32'hc);
		wr(8'h14, 32'hfff7);
		repeat (12) @(posedge pclk);
		acc(8'h04, 1'b0, 32'h0);
		chk(r[3:2], 2'h1);
		wr(8'h10, 32'h7);
		// Prescaled and falling-edge count clocks
		wr(8'h24, 32'h0);
		wr(8'h20, 32'ha);
		repeat (64) @(posedge pclk);
		wr(8'h20, 32'h7);
		acc(8'h24, 1'b0, 32'h0);
		chk_b(r[15:0] >= 16'h4 && r[15:0] <= 16'h5, 1'b1);
		wr(8'h14, 32'h0);
		wr(8'h10, 32'he);
		ext <= 2'h1;
		repeat (8) @(posedge pclk);
		ext <= 2'h0;
		repeat (8) @(posedge pclk);
		rd(8'h14, 32'h1);
		// Staggered timer steps once per eight clocks
		wr(8'h00, 32'h1);
		wr(8'h14, 32'h0);
		wr(8'h10, 32'h8);
		repeat (64) @(posedge pclk);
		wr(8'h10, 32'h7);
		acc(8'h14, 1'b0, 32'h0);
		chk_b(r[15:0] >= 16'h7 && r[15:0] <= 16'ha, 1'b1);
		finish_test();
	end
endmodule : cca_top_tb
`default_nettype wire
